// [common/host_port_pkg.sv]
// Package: constants and carrier types of the host processor bus port
package host_port_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 18;

  // ==========================================================
  // Bus modes, as seen on the mode select input
  localparam logic BUS_MODE_STROBES = 1'b0;
  localparam logic BUS_MODE_START = 1'b1;

  // ==========================================================
  // Timing: internal access latency, in ns, and derived cycle count
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_TIME_NS = 8;
  localparam int ACCESS_CYCLES_RAW =
    (ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYCLES = (ACCESS_CYCLES_RAW < 1) ? 1 :
    ACCESS_CYCLES_RAW;

  // ==========================================================
  // Reset values
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic write;
    logic [17:0] addr;
    logic [15:0] wdata;
  } core_req_s;

  typedef struct packed {
    logic [15:0] rdata;
    logic done;
  } core_rsp_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACK,
    ST_HOLD
  } port_state_e;

endpackage : host_port_pkg

// [rtl/host_irq_gen.sv]
// Module: registered interrupt request outputs of the host port
`timescale 1ns/1ps
`default_nettype none
module host_irq_gen
  import host_port_pkg::*;
#(
  parameter int EVENT_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [EVENT_W-1:0] event_pending,
  input wire logic timer2_expired,
  output logic primary_irq,
  output logic timer_irq
);

  // ==========================================================
  // Request registers
  wire any_event = |event_pending;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      primary_irq <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      primary_irq <= any_event;
      timer_irq <= timer2_expired;
    end
  end

  // ==========================================================
  // Checks
  AST_PRIMARY_FOLLOWS: assert property (@(posedge sys_clk)
    disable iff (!resetn) any_event |=> primary_irq)
    else $error("primary irq missed a pending event");
  AST_PRIMARY_QUIET: assert property (@(posedge sys_clk)
    disable iff (!resetn) !any_event |=> !primary_irq)
    else $error("primary irq without pending event");
  // The first edge after reset would compare against a value seen in reset
  AST_TIMER_IRQ: assert property (@(posedge sys_clk)
    disable iff (!resetn) $past(resetn)
    |-> timer_irq == $past(timer2_expired))
    else $error("timer irq not tied to timer expiry");

endmodule : host_irq_gen
`default_nettype wire

// [rtl/host_processor_bus_port.sv]
// Module: parallel host processor bus port into the device core space
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Data is 16 bits, bit 15 most significant, multiword values low word first.
// - Each cycle carries an 18-bit address selecting one 16-bit word.
// - Ready/acknowledge rises once write data taken or read data driven.
// - Primary interrupt asserts while any special event is pending.
// - Timer interrupt asserts when a second timer set counter expires.
// - All logic runs on the single master clock.
// - Master reset asynchronously clears every flip-flop.
module host_processor_bus_port
  import host_port_pkg::*;
#(
  parameter int EVENT_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic bus_mode,
  input wire logic host_chip_select_n,
  input wire logic host_write_strobe_n,
  input wire logic host_read_strobe_n,
  input wire logic [17:0] host_word_address,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  output logic host_ready_out,
  output logic host_ready_oe,
  output logic core_req_valid,
  output core_req_s core_req,
  input wire core_rsp_s core_rsp,
  input wire logic [EVENT_W-1:0] event_pending,
  input wire logic timer2_expired,
  output logic primary_irq,
  output logic timer_irq
);

  // ==========================================================
  // Pin decoding; in start mode the write pin is direction (high = read)
  function automatic logic pin_low(input logic pin_n);
    return pin_n == 1'b0;
  endfunction : pin_low

  wire selected = pin_low(host_chip_select_n);
  // A read strobe only counts while the write strobe is idle
  wire strobe_rd = pin_low(host_read_strobe_n) &&
    !pin_low(host_write_strobe_n);
  wire strobe_wr = pin_low(host_write_strobe_n);
  wire start_seen = pin_low(host_read_strobe_n);
  wire dir_write = pin_low(host_write_strobe_n);
  wire start_mode = (bus_mode == BUS_MODE_START);
  wire cycle_open = start_mode ? start_seen : (strobe_rd || strobe_wr);
  // both modes reduce to a request and a direction
  wire cycle_write = start_mode ? dir_write : strobe_wr;
  // Strobe mode ends when strobes drop; start mode ends on chip deselect
  wire cycle_over = start_mode ? !selected : !(strobe_rd || strobe_wr);

  port_state_e state;
  port_state_e next_state;
  logic write_cycle;
  logic [15:0] next_data_out;
  logic next_req_valid;

  // ==========================================================
  // Transfer sequencing
  always_comb begin
    next_state = state;
    next_req_valid = 1'b0;
    next_data_out = host_data_out;
    case (state)
      ST_IDLE: begin
        if (selected && cycle_open) begin
          next_state = ST_WAIT;
          next_req_valid = 1'b1;
        end
      end
      ST_WAIT: begin
        // Abort: the core access runs on, its late done is dropped in idle
        if (!selected) begin
          next_state = ST_IDLE;
        end else if (core_rsp.done) begin
          next_state = ST_ACK;
          if (!write_cycle) begin
            next_data_out = core_rsp.rdata;
          end
        end
      end
      ST_ACK: begin
        // Ready holds until the master ends the cycle
        if (!selected || cycle_over) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      write_cycle <= 1'b0;
      core_req_valid <= 1'b0;
      core_req <= '0;
      host_data_out <= DATA_RESET;
    end else begin
      state <= next_state;
      core_req_valid <= next_req_valid;
      host_data_out <= next_data_out;
      // Request fields hold after the pulse, so the core may sample late
      if (next_req_valid) begin
        write_cycle <= cycle_write;
        core_req.write <= cycle_write;
        core_req.addr <= host_word_address;
        core_req.wdata <= host_data_in;
      end
    end
  end

  // ==========================================================
  // Pin drivers; read data is loaded on the same edge that ready rises
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      host_data_oe <= 1'b0;
      host_ready_out <= 1'b0;
      host_ready_oe <= 1'b0;
    end else begin
      // Enable lags chip select a cycle: a late release for a clean pin
      host_ready_oe <= selected;
      host_ready_out <= (next_state == ST_ACK);
      host_data_oe <= selected && !write_cycle &&
        (next_state == ST_ACK);
    end
  end

  host_irq_gen #(
    .EVENT_W(EVENT_W)
  ) u_irq (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .event_pending(event_pending),
    .timer2_expired(timer2_expired),
    .primary_irq(primary_irq),
    .timer_irq(timer_irq)
  );

  // ==========================================================
  // Checks
  AST_DESELECT_HIZ: assert property (@(posedge sys_clk)
    disable iff (!resetn) !selected |=> !host_data_oe && !host_ready_oe)
    else $error("bus driven while deselected");
  AST_DESELECT_NO_READY: assert property (@(posedge sys_clk)
    disable iff (!resetn) !selected |=> !host_ready_out)
    else $error("ready asserted while deselected");
  AST_READY_AFTER_DONE: assert property (@(posedge sys_clk)
    disable iff (!resetn) state == ST_WAIT && selected && core_rsp.done
    |=> host_ready_out)
    else $error("ready missing after core completion");
  AST_NO_EARLY_READY: assert property (@(posedge sys_clk)
    disable iff (!resetn) $rose(host_ready_out) |-> $past(core_rsp.done))
    else $error("ready without core completion");

  // The core may change its read data once done falls; only the rise
  // of ready is held against it, later cycles must simply stand still
  AST_READ_DATA_VALID: assert property (@(posedge sys_clk)
    disable iff (!resetn) $rose(host_ready_out) && !write_cycle
    |-> host_data_oe && host_data_out == $past(core_rsp.rdata))
    else $error("ready on read without valid data");
  AST_READ_DATA_HOLD: assert property (@(posedge sys_clk)
    disable iff (!resetn) host_ready_out && $past(host_ready_out) &&
    !write_cycle |-> host_data_oe && $stable(host_data_out))
    else $error("read data changed while ready stands");

  // Ready must fall the cycle after the master closes the transfer
  AST_READY_RELEASE: assert property (@(posedge sys_clk)
    disable iff (!resetn) host_ready_out && selected && cycle_over
    |=> !host_ready_out)
    else $error("ready held after the master closed the transfer");
  AST_START_HOLD: assert property (@(posedge sys_clk)
    disable iff (!resetn) start_mode && host_ready_out && selected
    |=> host_ready_out)
    else $error("ready dropped inside a start mode transfer");

  AST_IGNORE_UNSELECTED: assert property (@(posedge sys_clk)
    disable iff (!resetn) state == ST_IDLE && !selected |=> !core_req_valid)
    else $error("request issued without chip select");
  AST_ADDR_CAPTURE: assert property (@(posedge sys_clk)
    disable iff (!resetn) state == ST_IDLE && selected && cycle_open
    |=> core_req_valid && core_req.addr == $past(host_word_address))
    else $error("address not captured");
  // Write data is taken at the request edge, never later
  AST_WDATA_CAPTURE: assert property (@(posedge sys_clk)
    disable iff (!resetn) state == ST_IDLE && selected && cycle_open
    |=> core_req.wdata == $past(host_data_in))
    else $error("write data not captured");
  AST_WRITE_NO_DRIVE: assert property (@(posedge sys_clk)
    disable iff (!resetn) write_cycle |-> !host_data_oe)
    else $error("data bus driven during a write");
  AST_DIRECTION: assert property (@(posedge sys_clk)
    disable iff (!resetn) state == ST_IDLE && selected && cycle_open
    |=> core_req.write == $past(cycle_write))
    else $error("direction not captured");
  AST_SINGLE_REQ: assert property (@(posedge sys_clk)
    disable iff (!resetn) core_req_valid |=> !core_req_valid)
    else $error("request pulse longer than one cycle");

  COV_WRITE: cover property (@(posedge sys_clk)
    host_ready_out && write_cycle);
  COV_READ: cover property (@(posedge sys_clk)
    host_ready_out && !write_cycle);
  COV_START_MODE: cover property (@(posedge sys_clk)
    start_mode && core_req_valid);
  COV_ABORT: cover property (@(posedge sys_clk)
    state == ST_WAIT && !selected);
  COV_BACK_TO_BACK: cover property (@(posedge sys_clk)
    host_ready_out ##1 !host_ready_out ##[1:4] core_req_valid);

endmodule : host_processor_bus_port
`default_nettype wire

// [bench/host_master.sv]
// Host bus master model for the device's processor port
`timescale 1ns/1ps
`default_nettype none
module host_master
  import host_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic ready,
  input wire logic [15:0] bus,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [17:0] addr,
  output logic [15:0] wdata,
  output logic drive
);
  // ==========================================
  // Idle: deselected, strobes high, data released
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = '0;
    wdata = '0;
    drive = 1'b0;
  end
  // ==========================================
  // One word per cycle; all held until ready is sampled high or lim edges pass
  task automatic xfer(input logic mode, input logic wr,
      input logic [17:0] a, input logic [15:0] d, input int lim,
      output logic [15:0] q, output logic ok);
    @(negedge sys_clk);
    cs_n = 1'b0;
    addr = a;
    wdata = d;
    drive = wr;
    wr_n = !wr;
    rd_n = (mode == BUS_MODE_START) ? 1'b0 : wr;
    ok = 1'b0;
    q = 'x;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge sys_clk);
      if (ready === 1'b1) begin
        ok = 1'b1;
        q = bus;
      end
    end
    @(negedge sys_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    drive = 1'b0;
  endtask : xfer
endmodule : host_master
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the host processor bus port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import host_port_pkg::*;
;
  logic sys_clk, resetn, bus_mode, cs_n, wr_n, rd_n, drive;
  logic t2 = 1'b0;
  logic data_oe, ready_out, ready_oe, req_valid, ok, p_irq, t_irq;
  logic [17:0] addr, a;
  logic [15:0] wdata, data_out, bus, q, d;
  logic [31:0] r, ri;
  logic [7:0] ev = 8'h00;
  core_req_s req;
  core_rsp_s rsp = '0;
  logic [31:0] seed = 32'h3f50f7b5;
  int n_fail = 0;
  int checks = 0;
  int lat = 1;
  int up = 0;
  // Plain word array; every read in the run follows a write to its address
  logic [15:0] mem [0:262143];
  // Pull-up holds the data bus high when nobody drives it
  assign bus = data_oe ? data_out : (drive ? wdata : 16'hffff);
  host_processor_bus_port #(.EVENT_W(8)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .bus_mode(bus_mode), .host_chip_select_n(cs_n),
    .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
    .host_word_address(addr), .host_data_in(bus),
    .host_data_out(data_out), .host_data_oe(data_oe),
    .host_ready_out(ready_out), .host_ready_oe(ready_oe),
    .core_req_valid(req_valid), .core_req(req), .core_rsp(rsp),
    .event_pending(ev), .timer2_expired(t2), .primary_irq(p_irq),
    .timer_irq(t_irq));
  host_master m (.sys_clk(sys_clk), .ready(ready_oe & ready_out),
    .bus(bus), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
    .wdata(wdata), .drive(drive));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic c, input string msg);
    checks++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic go(input logic md, input logic wr);
    bus_mode = md;
    m.xfer(md, wr, a, d, 40, q, ok);
    chk(ok === 1'b1, "no ready");
    chk(req.write === wr && req.addr === a, "bad request");
    if (wr) chk(req.wdata === d, "bad write data");
    else chk(q === d, "bad read data");
    repeat (2) @(negedge sys_clk);
    chk(data_oe === 1'b0 && ready_oe === 1'b0, "bus held");
  endtask : go
  // ==========================================
  // Core side: slow or prompt, data scrambled after done
  always @(posedge sys_clk) begin
    if (req_valid === 1'b1) begin
      if (req.write === 1'b1) mem[req.addr] = req.wdata;
      repeat (lat) @(negedge sys_clk);
      rsp.rdata = mem[req.addr];
      rsp.done = 1'b1;
      @(negedge sys_clk);
      rsp.done = 1'b0;
      rsp.rdata = ~rsp.rdata;
    end
  end
  // ==========================================
  // Interrupt inputs: random, checked one cycle later
  always @(negedge sys_clk) begin
    if (up > 2 && resetn === 1'b1) begin
      chk(p_irq === (|ev), "primary irq");
      chk(t_irq === t2, "timer irq");
    end
    up = resetn ? up + 1 : 0;
    ri = rnd();
    ev = ri[1:0] == 2'h0 ? 8'h00 : ri[15:8];
    t2 = ri[4];
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    resetn = 1'b0;
    bus_mode = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    // Corner addresses and data first, then random
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      a = (i < 2) ? {18{i[0]}} : r[17:0];
      d = (i < 2) ? 16'h8001 : r[31:16];
      lat = r[2:0] + 1;
      go(i[0], 1'b1);
      go(!i[0], 1'b0);
    end
    // Deselect while the core is still busy: no ready may follow
    lat = 20;
    bus_mode = BUS_MODE_STROBES;
    m.xfer(1'b0, 1'b0, a, d, 5, q, ok);
    repeat (25) begin
      @(negedge sys_clk);
      if (ready_out === 1'b1 && ready_oe === 1'b1) ok = 1'b1;
    end
    chk(ok === 1'b0, "ready after abort");
    // Reset in mid-run clears both interrupts, the request pulse and both bus enables at once
    resetn = 1'b0;
    #1;
    chk({p_irq, t_irq, req_valid, data_oe, ready_oe} === 5'h00, "rst");
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    lat = 1;
    go(1'b1, 1'b0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
